// [logic/sep_pkg.sv]
// Package for the serial command port of the byte memory.
// Assumes a 125 MHz system clock sampling all serial pins.
`default_nettype none
package sep_pkg;
    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_LATCH_SET   = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_RD   = 8'h05;
    localparam logic [7:0] OP_STATUS_WR   = 8'h01;
    localparam logic [7:0] OP_MEM_RD      = 8'h03;
    localparam logic [7:0] OP_MEM_WR      = 8'h02;
    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int ST_BUSY  = 0;
    localparam int ST_WEL   = 1;
    localparam int ST_BP0   = 2;
    localparam int ST_BP1   = 3;
    localparam int ST_LOCK  = 4;
    localparam int ST_IDSEL = 6;
    localparam int ST_PPEN  = 7;
    localparam logic [7:0] STATUS_RST     = 8'h00;
    localparam logic [7:0] STATUS_WR_MASK = 8'hDC;
    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int ADDR_W      = 15;
    localparam int ID_ADDR_W   = 6;
    localparam int CLK_MHZ     = 125;
    localparam int PROG_TIME_US = 5000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    // Frame phases
    typedef enum logic [2:0] {
        SEP_OPC  = 3'b000,
        SEP_ADRH = 3'b001,
        SEP_ADRL = 3'b010,
        SEP_DATA = 3'b011,
        SEP_STAT = 3'b100,
        SEP_IGN  = 3'b101
    } sep_phase_e;
endpackage
`default_nettype wire

// [logic/sep_sync.sv]
// Two flip-flop synchroniser for a group of pins.
// Assumes the inputs are asynchronous to clk.
`default_nettype none
module sep_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] dout_nxt;

    // Next values: shift one stage
    always_comb begin
        meta_nxt = din;
        dout_nxt = meta_r;
    end

    // Registers, reset to all ones (idle pins)
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '1;
            dout   <= '1;
        end else begin
            meta_r <= meta_nxt;
            dout   <= dout_nxt;
        end
    end
endmodule
`default_nettype wire

// [logic/sep_port.sv]
// Serial command port: opcode decode, status, array and id page access.
// Assumes a host SPI master in mode 0 or 3 on csN, sck, si, holdN, wpN.
// Contract
// - Sample serial input on rising serial clock edges.
// - Change serial output on falling serial clock edges.
// - Output floats while deselected; standby unless programming.
// - Write-protect pin high never blocks a write.
// - Pin low with protect enable set refuses status writes.
// - Paused frame keeps its state and resumes.
// - First eight bits go to an eight-bit instruction register.
// - Unknown opcodes are ignored for the rest of the frame.
// - Latch set 06, latch clear 04, status read 05.
// - Status write 01, memory read 03, memory write 02.
// - Memory read returns the addressed byte.
// - Id page select routes accesses to the 64-byte page.
// - Id page lock is permanent and refuses page writes; here reset clears it.
// - Programming starts at select rising, ends within 5 ms.
// - Latch set sets, latch clear clears the enable latch.
// - While programming only status read is obeyed.
// - Busy bit is one for the whole programming cycle.
// - A 16-bit address follows; fifteen bits used.
`default_nettype none
module sep_port #(
    parameter int DEPTH       = 32768,
    parameter int ID_DEPTH    = 64,
    parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic csN,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic holdN,
    input  wire logic wpN,
    output logic      soOut,
    output logic      soOeN,
    output logic      busy
);
    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [4:0] pinS;
    sep_sync #(.W(5)) uSync (
        .clk  (clk),
        .rst_n(rst_n),
        .din  ({csN, sck, si, holdN, wpN}),
        .dout (pinS)
    );
    logic csS, sckS, siS, holdS, wpS;
    assign {csS, sckS, siS, holdS, wpS} = pinS;

    logic sckD_r, csD_r, holdD_r;
    logic sckRise, sckFall, csRise, active;
    // Hold freezes all clock edges so state is kept
    assign active  = !csS && holdD_r;
    assign sckRise = active && sckS && !sckD_r;
    assign sckFall = active && !sckS && sckD_r;
    assign csRise  = csS && !csD_r;

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    logic [7:0] mem_r [DEPTH];
    logic [7:0] idm_r [ID_DEPTH];
    logic [7:0] status_r, status_nxt;
    logic [7:0] opc_r, opc_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] out_r, out_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [7:0] wdat_r, wdat_nxt;
    logic       wpend_r, wpend_nxt;
    logic       spend_r, spend_nxt;
    logic       drive_r, drive_nxt;
    logic       so_r, so_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    sep_pkg::sep_phase_e ph_r, ph_nxt;
    logic [7:0] wsh;
    logic       wrOk, memWr, idWr;

    // Byte read helper
    function automatic logic [7:0] rd_byte(input logic [15:0] a, input logic idSel);
        rd_byte = idSel ? idm_r[a[sep_pkg::ID_ADDR_W-1:0]] : mem_r[a[sep_pkg::ADDR_W-1:0]];
    endfunction

    // Block protect check on a 15-bit address
    function automatic logic bp_hit(input logic [15:0] a, input logic [1:0] bp);
        case (bp)
            2'h1:    bp_hit = a[14] && a[13];
            2'h2:    bp_hit = a[14];
            2'h3:    bp_hit = 1'b1;
            default: bp_hit = 1'b0;
        endcase
    endfunction

    assign wsh = {sh_r[6:0], siS};
    // Pin high never blocks; low with enable blocks status writes
    assign wrOk = status_r[sep_pkg::ST_WEL] &&
                  (wpS || !status_r[sep_pkg::ST_PPEN]);
    assign memWr = wpend_r && !status_r[sep_pkg::ST_IDSEL];
    assign idWr  = wpend_r && status_r[sep_pkg::ST_IDSEL];

    // ------------------------------------------------------------
    // Frame decoder next state
    // ------------------------------------------------------------
    always_comb begin
        ph_nxt     = ph_r;
        opc_nxt    = opc_r;
        sh_nxt     = sh_r;
        bit_nxt    = bit_r;
        addr_nxt   = addr_r;
        wdat_nxt   = wdat_r;
        wpend_nxt  = wpend_r;
        spend_nxt  = spend_r;
        out_nxt    = out_r;
        drive_nxt  = drive_r;
        so_nxt     = so_r;
        status_nxt = status_r;
        cnt_nxt    = cnt_r;
        if (csS) begin
            // Deselected: float output, reset frame
            ph_nxt    = sep_pkg::SEP_OPC;
            bit_nxt   = 3'h0;
            drive_nxt = 1'b0;
        end
        if (sckRise) begin
            sh_nxt  = wsh;
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
                case (ph_r)
                    sep_pkg::SEP_OPC: begin
                        opc_nxt = wsh;
                        ph_nxt  = sep_pkg::SEP_IGN;
                        if (wsh == sep_pkg::OP_STATUS_RD) begin
                            ph_nxt  = sep_pkg::SEP_STAT;
                            out_nxt = status_r[sep_pkg::ST_BUSY] ? 8'hFF : status_r;
                        end else if (status_r[sep_pkg::ST_BUSY]) begin
                            ph_nxt = sep_pkg::SEP_IGN;
                        end else if (wsh == sep_pkg::OP_LATCH_SET) begin
                            ph_nxt = sep_pkg::SEP_IGN;
                            status_nxt[sep_pkg::ST_WEL] = 1'b1;
                        end else if (wsh == sep_pkg::OP_LATCH_CLEAR) begin
                            status_nxt[sep_pkg::ST_WEL] = 1'b0;
                        end else if (wsh == sep_pkg::OP_STATUS_WR) begin
                            ph_nxt = sep_pkg::SEP_DATA;
                        end else if (wsh == sep_pkg::OP_MEM_RD ||
                                     wsh == sep_pkg::OP_MEM_WR) begin
                            ph_nxt = sep_pkg::SEP_ADRH;
                        end
                        // Anything else stays ignored
                    end
                    sep_pkg::SEP_ADRH: begin
                        addr_nxt[15:8] = wsh;
                        ph_nxt = sep_pkg::SEP_ADRL;
                    end
                    sep_pkg::SEP_ADRL: begin
                        addr_nxt[7:0] = wsh;
                        ph_nxt = sep_pkg::SEP_DATA;
                        if (opc_r == sep_pkg::OP_MEM_RD) begin
                            out_nxt = rd_byte({addr_r[15:8], wsh},
                                              status_r[sep_pkg::ST_IDSEL]);
                        end
                    end
                    sep_pkg::SEP_DATA: begin
                        if (opc_r == sep_pkg::OP_STATUS_WR) begin
                            spend_nxt = wrOk;
                            wdat_nxt  = wsh;
                        end else if (opc_r == sep_pkg::OP_MEM_WR) begin
                            wpend_nxt = status_r[sep_pkg::ST_WEL];
                            wdat_nxt  = wsh;
                        end else if (opc_r == sep_pkg::OP_MEM_RD) begin
                            addr_nxt  = addr_r + 16'h0001;
                            out_nxt   = rd_byte(addr_r + 16'h0001,
                                                status_r[sep_pkg::ST_IDSEL]);
                        end
                    end
                    default: ph_nxt = ph_r;
                endcase
            end
        end
        if (sckFall) begin
            // Drive only while read or status data is returned
            if ((ph_r == sep_pkg::SEP_STAT) ||
                (ph_r == sep_pkg::SEP_DATA && opc_r == sep_pkg::OP_MEM_RD)) begin
                drive_nxt = 1'b1;
                so_nxt    = out_r[3'h7 - bit_r];
            end
        end
        // Frame end commits a pending write and starts programming
        if (csRise && (wpend_r || spend_r)) begin
            status_nxt[sep_pkg::ST_WEL]  = 1'b0;
            wpend_nxt = 1'b0;
            spend_nxt = 1'b0;
            if (spend_r) begin
                // Select and lock set together drop the written value; only the latch clears and busy sets
                if (!(wdat_r[sep_pkg::ST_IDSEL] && wdat_r[sep_pkg::ST_LOCK])) begin
                    status_nxt = (status_r & ~sep_pkg::STATUS_WR_MASK) |
                                 (wdat_r & sep_pkg::STATUS_WR_MASK);
                    status_nxt[sep_pkg::ST_WEL] = 1'b0;
                    // Status writes never clear the lock; only reset does
                    status_nxt[sep_pkg::ST_LOCK] = status_r[sep_pkg::ST_LOCK] |
                                                   wdat_r[sep_pkg::ST_LOCK];
                end
            end else begin
                // A memory write frame ends the id page selection
                status_nxt[sep_pkg::ST_IDSEL] = 1'b0;
            end
            status_nxt[sep_pkg::ST_BUSY] = 1'b1;
            cnt_nxt = 32'(PROG_CYCLES - 1);
        end else if (status_r[sep_pkg::ST_BUSY]) begin
            if (cnt_r == 32'h0) begin
                status_nxt[sep_pkg::ST_BUSY] = 1'b0;
            end else begin
                cnt_nxt = cnt_r - 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sckD_r   <= 1'b1;                                // Matches the synchroniser reset
            csD_r    <= 1'b1;
            holdD_r  <= 1'b1;
            ph_r     <= sep_pkg::SEP_OPC;
            opc_r    <= 8'h00;
            sh_r     <= 8'h00;
            bit_r    <= 3'h0;
            addr_r   <= 16'h0000;
            wdat_r   <= 8'h00;
            wpend_r  <= 1'b0;
            spend_r  <= 1'b0;
            out_r    <= 8'h00;
            drive_r  <= 1'b0;
            so_r     <= 1'b0;
            status_r <= sep_pkg::STATUS_RST;
            cnt_r    <= 32'h0;
            soOut    <= 1'b0;
            soOeN    <= 1'b1;
            busy     <= 1'b0;
        end else begin
            sckD_r   <= sckS;
            csD_r    <= csS;
            holdD_r  <= holdS;
            ph_r     <= ph_nxt;
            opc_r    <= opc_nxt;
            sh_r     <= sh_nxt;
            bit_r    <= bit_nxt;
            addr_r   <= addr_nxt;
            wdat_r   <= wdat_nxt;
            wpend_r  <= wpend_nxt;
            spend_r  <= spend_nxt;
            out_r    <= out_nxt;
            drive_r  <= drive_nxt;
            so_r     <= so_nxt;
            status_r <= status_nxt;
            cnt_r    <= cnt_nxt;
            soOut    <= so_nxt;
            soOeN    <= !(drive_nxt && !csS && holdS);
            busy     <= status_nxt[sep_pkg::ST_BUSY];
        end
    end

    // Array writes on the frame end, block and page locks applied
    always_ff @(posedge clk) begin
        if (csRise && memWr && !bp_hit(addr_r, status_r[3:2])) begin
            mem_r[addr_r[sep_pkg::ADDR_W-1:0]] <= wdat_r;
        end
        if (csRise && idWr && !status_r[sep_pkg::ST_LOCK] &&
            status_r[3:2] != 2'h3) begin
            idm_r[addr_r[sep_pkg::ID_ADDR_W-1:0]] <= wdat_r;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence frameEnd_s;
        csRise && (wpend_r || spend_r);
    endsequence
    float_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        csS |=> soOeN) else $error("output driven while deselected");
    prog_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        frameEnd_s |=> status_r[0] ##1 busy) else $error("programming not started");
    busy_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (status_r[0] && cnt_r != 32'h0) |=> status_r[0]) else $error("busy dropped early");
    wel_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sckRise && bit_r == 3'h7 && ph_r == sep_pkg::SEP_OPC && !status_r[0]
         && wsh == sep_pkg::OP_LATCH_SET) |=> status_r[1]) else $error("latch not set");
    ign_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sckRise && bit_r == 3'h7 && ph_r == sep_pkg::SEP_OPC && status_r[0]
         && wsh != sep_pkg::OP_STATUS_RD) |=> ph_r == sep_pkg::SEP_IGN)
        else $error("command obeyed while busy");
    bad_opc_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ph_r == sep_pkg::SEP_IGN && !csS) |=> ph_r == sep_pkg::SEP_IGN)
        else $error("ignored frame resumed");
    hold_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!holdD_r && !csS) |=> $stable(bit_r)) else $error("state moved in hold");
    wp_status_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!wpS && status_r[7] && sckRise && bit_r == 3'h7 && ph_r == sep_pkg::SEP_DATA
         && opc_r == sep_pkg::OP_STATUS_WR) |=> !spend_r) else $error("protected status write");
endmodule
`default_nettype wire

// [verification/sep_host.sv]
// Host serial master model for the command port, SPI mode 0 or 3.
// Assumes clk is the system clock; the serial clock runs on its own timing.
`default_nettype none
module sep_host (
    input  wire logic clk,
    input  wire logic cpol,
    output logic      csN,
    output logic      sck,
    output logic      si,
    output logic      holdN,
    input  wire logic soOut,
    input  wire logic soOeN
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam real HALF_T = 62.5;  // Serial clock half period in ns, 125 ns period
    localparam int  GAP    = 8;     // Select setup in clk cycles

    // Idle levels at time zero
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        holdN = 1'b1;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Select falls with the serial clock at the idle level of the mode
    task automatic sel();
        idle(1);
        sck <= cpol;
        idle(2);
        csN <= 1'b0;
        idle(GAP);
    endtask

    // Select rises; the released data line shows the inverse of its last value
    task automatic desel();
        csN <= 1'b1;
        si <= ~si;
        idle(2 * GAP);
    endtask

    // One byte each way, most significant bit first; counts driven output bits.
    // An undriven output line reads as the inverse of its last value.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output int drv);
        drv = 0;
        for (int i = 7; i >= 0; i--) begin
            if (cpol) begin
                sck <= 1'b0;
            end
            si <= tx[i];
            #HALF_T;
            sck <= 1'b1;
            rx[i] = (soOeN === 1'b0) ? soOut : ~soOut;
            if (soOeN === 1'b0) begin
                drv++;
            end
            #HALF_T;
            if (!cpol) begin
                sck <= 1'b0;
            end
        end
    endtask

    // Pause with the serial clock low; reports the output enable while paused
    task automatic pause(input int n, output logic oeN);
        holdN <= 1'b0;
        idle(n);
        oeN = soOeN;
        holdN <= 1'b1;
        #HALF_T;
    endtask
endmodule
`default_nettype wire

// [verification/sep_port_test.sv]
// Self-checking bench for the serial command port.
// Assumes the host model in sep_host.sv and a short programming time.
`default_nettype none
module sep_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PROG = 1200;  // Shortened programming cycle, outlasts a status and a read frame

    logic       clk;
    logic       rst_n;
    logic       wpN;
    logic       csN;
    logic       sck;
    logic       si;
    logic       holdN;
    logic       soOut;
    logic       soOeN;
    logic       busy;
    logic       oeN;
    logic       cpol;
    logic [7:0] rd;
    int         drv;
    int         dh;
    int         dl;
    int         n_mismatch = 0;
    int         checks = 0;

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        wpN = 1'b1;
        cpol = 1'b0;
    end
    always #4 clk = ~clk;

    sep_port #(.PROG_CYCLES(PROG)) sep_port_inst (
        .clk(clk), .rst_n(rst_n), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
        .wpN(wpN), .soOut(soOut), .soOeN(soOeN), .busy(busy)
    );
    sep_host sep_host_inst (
        .clk(clk), .cpol(cpol), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
        .soOut(soOut), .soOeN(soOeN)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One session of nb bytes from the top of tx; last byte read back in rd
    task automatic frame(input logic [31:0] tx, input int nb);
        int d;
        dh = 0;
        sep_host_inst.sel();
        for (int i = 0; i < nb; i++) begin
            sep_host_inst.xfer(tx[31 - 8 * i -: 8], rd, d);
            if (i < nb - 1) dh += d;
            else dl = d;
        end
        sep_host_inst.desel();
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < PROG + 16) begin
            @(posedge clk);
            n++;
        end
        chk("busy clear", 8'h00, {7'h00, busy});
    endtask

    task automatic status_read_cmd(input logic [7:0] exp);
        frame({8'h05, 24'h0}, 2);
        chk("status", exp, rd);
    endtask

    task automatic status_write_cmd(input logic [7:0] v);
        frame({8'h06, 24'h0}, 1);
        frame({8'h01, v, 16'h0}, 2);
        wait_ready();
    endtask

    task automatic wrm(input logic [15:0] a, input logic [7:0] v);
        frame({8'h06, 24'h0}, 1);
        frame({8'h02, a, v}, 4);
        wait_ready();
    endtask

    task automatic rdm(input logic [15:0] a, input logic [7:0] exp);
        frame({8'h03, a, 8'h00}, 4);
        chk("read data", exp, rd);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        sep_host_inst.idle(3);
        chk("idle output enable", 8'h01, {7'h00, soOeN});
        chk("idle busy", 8'h00, {7'h00, busy});
        status_read_cmd(8'h00);
        $display("t_reset done");
    endtask

    task automatic t_latch();
        frame({8'h06, 24'h0}, 1);
        status_read_cmd(8'h02);
        chk("driven head bits", 8'h00, 8'(dh));
        chk("driven data bits", 8'h08, 8'(dl));
        frame({8'h04, 24'h0}, 1);
        status_read_cmd(8'h00);
        $display("t_latch done");
    endtask

    task automatic t_write();
        frame({8'h06, 24'h0}, 1);
        frame({8'h02, 16'h8005, 8'h11}, 4);
        chk("busy set", 8'h01, {7'h00, busy});
        status_read_cmd(8'hFF);
        frame({8'h03, 16'h0005, 8'h00}, 4);
        chk("read while busy", 8'h00, 8'(dl));
        wait_ready();
        rdm(16'h0005, 8'h11);
        sep_host_inst.sel();
        sep_host_inst.xfer(8'h03, rd, drv);
        sep_host_inst.xfer(8'h00, rd, drv);
        sep_host_inst.xfer(8'h05, rd, drv);
        sep_host_inst.pause(24, oeN);
        chk("output during hold", 8'h01, {7'h00, oeN});
        sep_host_inst.xfer(8'h00, rd, drv);
        chk("read after hold", 8'h11, rd);
        sep_host_inst.desel();
        chk("deselected output", 8'h01, {7'h00, soOeN});
        $display("t_write done");
    endtask

    task automatic t_unknown();
        frame({8'hFF, 8'h05, 8'h03, 8'h00}, 4);
        chk("unknown opcode output", 8'h00, 8'(dh + dl));
        status_read_cmd(8'h00);
        $display("t_unknown done");
    endtask

    // Serial clock idling high between frames
    task automatic t_mode3();
        cpol <= 1'b1;
        status_read_cmd(8'h00);
        chk("mode 3 driven bits", 8'h08, 8'(dl));
        rdm(16'h0005, 8'h11);
        cpol <= 1'b0;
        $display("t_mode3 done");
    endtask

    task automatic t_protect();
        status_write_cmd(8'h80);
        status_read_cmd(8'h80);
        wpN <= 1'b0;
        status_write_cmd(8'h00);
        frame({8'h04, 24'h0}, 1);
        status_read_cmd(8'h80);
        wpN <= 1'b1;
        status_write_cmd(8'h00);
        status_read_cmd(8'h00);
        $display("t_protect done");
    endtask

    task automatic t_idpage();
        status_write_cmd(8'h40);
        wrm(16'h0005, 8'h3C);
        rdm(16'h0005, 8'h11);
        status_write_cmd(8'h40);
        rdm(16'h0005, 8'h3C);
        status_write_cmd(8'h10);
        status_write_cmd(8'h40);
        wrm(16'h0005, 8'h77);
        status_write_cmd(8'h40);
        rdm(16'h0005, 8'h3C);
        status_write_cmd(8'h50);
        status_read_cmd(8'h50);
        $display("t_idpage done");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        t_reset();
        t_latch();
        t_write();
        t_mode3();
        t_unknown();
        t_protect();
        t_idpage();
        print_verdict();
    end

    // Watchdog, well beyond the expected run length
    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
